// ---- hdl/sbu_shift_bit_unit.sv ----
`timescale 1ns/1ps
`include "sbu_defs.svh"
module sbu_shift_bit_unit
    import sbu_pkg::*;
(
    sys_clk,
    resetn,
    clkEn,
    opValid,
    opCode,
    useMemory,
    bitFromReg,
    bitImm,
    bitRegValue,
    regValue,
    carryFlag,
    memRdData,
    memRdValid,
    opBusy,
    regWrEn,
    regWrData,
    memRdReq,
    memWrReq,
    memWrData,
    carryWrEn,
    carryWrData,
    zeroWrEn,
    zeroWrData,
    negWrEn,
    negWrData,
    opDone
);
    input wire logic sys_clk;
    input wire logic resetn;
    input wire logic clkEn;
    input wire logic opValid;
    input wire sbu_pkg::sbu_op_t opCode;
    input wire logic useMemory;
    input wire logic bitFromReg;
    input wire logic [2:0] bitImm;
    input wire logic [7:0] bitRegValue;
    input wire logic [7:0] regValue;
    input wire logic carryFlag;
    input wire logic [7:0] memRdData;
    input wire logic memRdValid;
    output logic opBusy;
    output logic regWrEn;
    output logic [7:0] regWrData;
    output logic memRdReq;
    output logic memWrReq;
    output logic [7:0] memWrData;
    output logic carryWrEn;
    output logic carryWrData;
    output logic zeroWrEn;
    output logic zeroWrData;
    output logic negWrEn;
    output logic negWrData;
    output logic opDone;

    import sbu_pkg::*;

    sbu_state_t state_reg;
    sbu_state_t state_next;
    sbu_op_t op_reg;
    logic [2:0] bitNum_reg;
    logic carry_reg;

    logic isShift;
    logic isInvOp;
    logic [2:0] bitNum;
    logic [7:0] shiftByte;
    logic shiftCarry;
    logic [7:0] engIn;
    logic [2:0] engBit;
    sbu_op_t engOp;
    logic engCarry;
    logic [7:0] engByte;
    logic engCarryOut;
    logic engZero;
    logic engWrByte;
    logic engWrCarry;
    logic engWrZero;

    assign isShift = (opCode >= SBU_OP_ARITH_SHIFT_LEFT) &&
                     (opCode <= SBU_OP_ROTATE_RIGHT_VIA_CARRY);
    assign isInvOp = (opCode == SBU_OP_CARRY_AND_INV_BIT) ||
                     (opCode == SBU_OP_CARRY_OR_INV_BIT) ||
                     (opCode == SBU_OP_CARRY_XOR_INV_BIT) ||
                     (opCode == SBU_OP_INV_BIT_TO_CARRY) ||
                     (opCode == SBU_OP_INV_CARRY_TO_BIT);
    // inverted forms have no register bit-number encoding
    assign bitNum = (bitFromReg && !isInvOp) ?
                    bitRegValue[`SBU_BITNUM_W-1:0] : bitImm;

    always_comb begin
        shiftByte = regValue;
        shiftCarry = carryFlag;
        case (opCode)
            SBU_OP_ARITH_SHIFT_LEFT: begin
                shiftByte = {regValue[`SBU_MSB-1:`SBU_LSB], 1'b0};
                shiftCarry = regValue[`SBU_MSB];
            end
            SBU_OP_ARITH_SHIFT_RIGHT: begin
                // sign bit replicated
                shiftByte = {regValue[`SBU_MSB], regValue[`SBU_MSB:`SBU_LSB+1]};
                shiftCarry = regValue[`SBU_LSB];
            end
            SBU_OP_LOGIC_SHIFT_LEFT: begin
                shiftByte = {regValue[`SBU_MSB-1:`SBU_LSB], 1'b0};
                shiftCarry = regValue[`SBU_MSB];
            end
            SBU_OP_LOGIC_SHIFT_RIGHT: begin
                shiftByte = {1'b0, regValue[`SBU_MSB:`SBU_LSB+1]};
                shiftCarry = regValue[`SBU_LSB];
            end
            SBU_OP_ROTATE_LEFT: begin
                shiftByte = {regValue[`SBU_MSB-1:`SBU_LSB], regValue[`SBU_MSB]};
                shiftCarry = regValue[`SBU_MSB];
            end
            SBU_OP_ROTATE_RIGHT: begin
                shiftByte = {regValue[`SBU_LSB], regValue[`SBU_MSB:`SBU_LSB+1]};
                shiftCarry = regValue[`SBU_LSB];
            end
            SBU_OP_ROTATE_LEFT_VIA_CARRY: begin
                shiftByte = {regValue[`SBU_MSB-1:`SBU_LSB], carryFlag};
                shiftCarry = regValue[`SBU_MSB];
            end
            SBU_OP_ROTATE_RIGHT_VIA_CARRY: begin
                shiftByte = {carryFlag, regValue[`SBU_MSB:`SBU_LSB+1]};
                shiftCarry = regValue[`SBU_LSB];
            end
            default: begin
                shiftByte = regValue;
            end
        endcase
    end

    // memory path uses latched op so decoder inputs may move on
    assign engOp = (state_reg == SBU_ST_IDLE) ? opCode : op_reg;
    assign engIn = (state_reg == SBU_ST_IDLE) ? regValue : memRdData;
    assign engBit = (state_reg == SBU_ST_IDLE) ? bitNum : bitNum_reg;
    assign engCarry = (state_reg == SBU_ST_IDLE) ? carryFlag : carry_reg;

    sbu_bit_engine uEngine (
        .op(engOp),
        .operand(engIn),
        .bitNum(engBit),
        .carryIn(engCarry),
        .resultByte(engByte),
        .carryOut(engCarryOut),
        .zeroOut(engZero),
        .writesByte(engWrByte),
        .writesCarry(engWrCarry),
        .writesZero(engWrZero)
    );

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SBU_ST_IDLE: begin
                if (opValid && useMemory && !isShift && opCode != SBU_OP_NOP) begin
                    state_next = SBU_ST_READ;
                end
            end
            SBU_ST_READ: begin
                if (memRdValid) begin
                    state_next = SBU_ST_WRITE;
                end
            end
            SBU_ST_WRITE: begin
                state_next = SBU_ST_IDLE;
            end
            default: begin
                state_next = SBU_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_reg <= SBU_ST_IDLE;
        end else if (clkEn) begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            op_reg <= SBU_OP_NOP;
            bitNum_reg <= 3'h0;
            carry_reg <= 1'b0;
        end else if (clkEn && state_reg == SBU_ST_IDLE && state_next == SBU_ST_READ) begin
            op_reg <= opCode;
            bitNum_reg <= bitNum;
            carry_reg <= carryFlag;
        end
    end

    // result outputs registered; one-cycle strobes
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            regWrEn <= 1'b0;
            regWrData <= `SBU_ZERO_BYTE;
            memWrReq <= 1'b0;
            memWrData <= `SBU_ZERO_BYTE;
            carryWrEn <= 1'b0;
            carryWrData <= 1'b0;
            zeroWrEn <= 1'b0;
            zeroWrData <= 1'b0;
            negWrEn <= 1'b0;
            negWrData <= 1'b0;
            opDone <= 1'b0;
        end else if (clkEn) begin
            regWrEn <= 1'b0;
            memWrReq <= 1'b0;
            carryWrEn <= 1'b0;
            zeroWrEn <= 1'b0;
            negWrEn <= 1'b0;
            opDone <= 1'b0;
            if (state_reg == SBU_ST_IDLE && opValid && opCode != SBU_OP_NOP) begin
                if (isShift) begin
                    regWrEn <= 1'b1;
                    regWrData <= shiftByte;
                    carryWrEn <= 1'b1;
                    carryWrData <= shiftCarry;
                    zeroWrEn <= 1'b1;
                    zeroWrData <= (shiftByte == `SBU_ZERO_BYTE);
                    negWrEn <= 1'b1;
                    negWrData <= shiftByte[`SBU_MSB];
                    opDone <= 1'b1;
                end else if (!useMemory) begin
                    regWrEn <= engWrByte;
                    regWrData <= engByte;
                    carryWrEn <= engWrCarry;
                    carryWrData <= engCarryOut;
                    zeroWrEn <= engWrZero;
                    zeroWrData <= engZero;
                    opDone <= 1'b1;
                end
            end else if (state_reg == SBU_ST_READ && memRdValid) begin
                // flag-only ops leave the memory byte untouched
                memWrReq <= engWrByte;
                memWrData <= engByte;
                carryWrEn <= engWrCarry;
                carryWrData <= engCarryOut;
                zeroWrEn <= engWrZero;
                zeroWrData <= engZero;
            end else if (state_reg == SBU_ST_WRITE) begin
                opDone <= 1'b1;
            end
        end
    end

    assign memRdReq = (state_reg == SBU_ST_READ);
    assign opBusy = (state_reg != SBU_ST_IDLE);

    AST_SHL_CARRY: assert property (@(posedge sys_clk) disable iff (!resetn)
        clkEn && state_reg == SBU_ST_IDLE && opValid && opCode == SBU_OP_LOGIC_SHIFT_LEFT
        |=> carryWrEn && carryWrData == $past(regValue[7])
            && regWrData == {$past(regValue[6:0]), 1'b0})
        else $error("shift left carry or data wrong");
    AST_ARITH_SHIFT_RIGHT_SIGN: assert property (@(posedge sys_clk) disable iff (!resetn)
        clkEn && state_reg == SBU_ST_IDLE && opValid && opCode == SBU_OP_ARITH_SHIFT_RIGHT
        |=> regWrData[7] == regWrData[6])
        else $error("arithmetic right lost sign");
    AST_ROTATE_RIGHT_WRAP: assert property (@(posedge sys_clk) disable iff (!resetn)
        clkEn && state_reg == SBU_ST_IDLE && opValid && opCode == SBU_OP_ROTATE_RIGHT
        |=> regWrData[7] == $past(regValue[0]))
        else $error("rotate right wrap wrong");
    AST_ROTATE_LEFT_VIA_CARRY_RING: assert property (@(posedge sys_clk) disable iff (!resetn)
        clkEn && state_reg == SBU_ST_IDLE && opValid && opCode == SBU_OP_ROTATE_LEFT_VIA_CARRY
        |=> regWrData[0] == $past(carryFlag))
        else $error("rotate via carry ring wrong");
    AST_ZERO_FLAG: assert property (@(posedge sys_clk) disable iff (!resetn)
        negWrEn |-> zeroWrData == (regWrData == 8'h00) && negWrData == regWrData[7])
        else $error("zero or negative flag mismatch");
    AST_TEST_NO_WRITE: assert property (@(posedge sys_clk) disable iff (!resetn)
        clkEn && state_reg == SBU_ST_IDLE && opValid && !useMemory && opCode == SBU_OP_BIT_TEST
        |=> zeroWrEn && !regWrEn && zeroWrData == ~$past(regValue[bitNum]))
        else $error("bit test wrong");
    AST_INV_IMM: assert property (@(posedge sys_clk) disable iff (!resetn)
        clkEn && state_reg == SBU_ST_IDLE && opValid && !useMemory
        && opCode == SBU_OP_INV_BIT_TO_CARRY
        |=> carryWrEn && carryWrData == ~$past(regValue[bitImm]))
        else $error("inverted op used register bit number");
    AST_MEM_SEQ: assert property (@(posedge sys_clk) disable iff (!resetn)
        memWrReq |-> ##1 (opDone || !clkEn) ##0 $past(state_reg) == SBU_ST_WRITE)
        else $error("memory write not followed by done");
    AST_MEM_NO_REG: assert property (@(posedge sys_clk) disable iff (!resetn)
        opBusy |-> !regWrEn)
        else $error("register written during memory op");
    COV_SHIFT: cover property (@(posedge sys_clk) disable iff (!resetn) negWrEn);
    COV_MEM_RMW: cover property (@(posedge sys_clk) disable iff (!resetn) memWrReq);
    COV_CARRY_OP: cover property (@(posedge sys_clk) disable iff (!resetn) carryWrEn && !negWrEn);
endmodule : sbu_shift_bit_unit

// ---- hdl/sbu_defs.svh ----
`ifndef SBU_DEFS_SVH
`define SBU_DEFS_SVH
`define SBU_MSB 7
`define SBU_LSB 0
`define SBU_BITNUM_W 3
`define SBU_ZERO_BYTE 8'h00
`define SBU_OP_W 5
`endif

// ---- hdl/sbu_pkg.sv ----
package sbu_pkg;
    typedef enum logic [4:0] {
        SBU_OP_NOP = 5'h00,
        SBU_OP_ARITH_SHIFT_LEFT = 5'h01,
        SBU_OP_ARITH_SHIFT_RIGHT = 5'h02,
        SBU_OP_LOGIC_SHIFT_LEFT = 5'h03,
        SBU_OP_LOGIC_SHIFT_RIGHT = 5'h04,
        SBU_OP_ROTATE_LEFT = 5'h05,
        SBU_OP_ROTATE_RIGHT = 5'h06,
        SBU_OP_ROTATE_LEFT_VIA_CARRY = 5'h07,
        SBU_OP_ROTATE_RIGHT_VIA_CARRY = 5'h08,
        SBU_OP_BIT_SET = 5'h09,
        SBU_OP_BIT_CLEAR = 5'h0A,
        SBU_OP_BIT_INVERT = 5'h0B,
        SBU_OP_BIT_TEST = 5'h0C,
        SBU_OP_CARRY_AND_BIT = 5'h0D,
        SBU_OP_CARRY_AND_INV_BIT = 5'h0E,
        SBU_OP_CARRY_OR_BIT = 5'h0F,
        SBU_OP_CARRY_OR_INV_BIT = 5'h10,
        SBU_OP_CARRY_XOR_BIT = 5'h11,
        SBU_OP_CARRY_XOR_INV_BIT = 5'h12,
        SBU_OP_BIT_TO_CARRY = 5'h13,
        SBU_OP_INV_BIT_TO_CARRY = 5'h14,
        SBU_OP_CARRY_TO_BIT = 5'h15,
        SBU_OP_INV_CARRY_TO_BIT = 5'h16
    } sbu_op_t;
    typedef enum logic [1:0] {
        SBU_ST_IDLE = 2'b00,
        SBU_ST_READ = 2'b01,
        SBU_ST_WRITE = 2'b11
    } sbu_state_t;
endpackage : sbu_pkg

// ---- hdl/sbu_bit_engine.sv ----
`timescale 1ns/1ps
`include "sbu_defs.svh"
module sbu_bit_engine
    import sbu_pkg::*;
(
    input wire sbu_pkg::sbu_op_t op,
    input wire logic [7:0] operand,
    input wire logic [2:0] bitNum,
    input wire logic carryIn,
    output logic [7:0] resultByte,
    output logic carryOut,
    output logic zeroOut,
    output logic writesByte,
    output logic writesCarry,
    output logic writesZero
);
    import sbu_pkg::*;

    logic [7:0] sel;
    logic b;
    assign sel = 8'h01 << bitNum;
    assign b = operand[bitNum];
    always_comb begin
        resultByte = operand;
        carryOut = carryIn;
        zeroOut = 1'b0;
        writesByte = 1'b0;
        writesCarry = 1'b0;
        writesZero = 1'b0;
        case (op)
            SBU_OP_BIT_SET: begin
                resultByte = operand | sel;
                writesByte = 1'b1;
            end
            SBU_OP_BIT_CLEAR: begin
                resultByte = operand & ~sel;
                writesByte = 1'b1;
            end
            SBU_OP_BIT_INVERT: begin
                resultByte = operand ^ sel;
                writesByte = 1'b1;
            end
            SBU_OP_BIT_TEST: begin
                zeroOut = ~b;
                writesZero = 1'b1;
            end
            SBU_OP_CARRY_AND_BIT: begin
                carryOut = carryIn & b;
                writesCarry = 1'b1;
            end
            SBU_OP_CARRY_AND_INV_BIT: begin
                carryOut = carryIn & ~b;
                writesCarry = 1'b1;
            end
            SBU_OP_CARRY_OR_BIT: begin
                carryOut = carryIn | b;
                writesCarry = 1'b1;
            end
            SBU_OP_CARRY_OR_INV_BIT: begin
                carryOut = carryIn | ~b;
                writesCarry = 1'b1;
            end
            SBU_OP_CARRY_XOR_BIT: begin
                carryOut = carryIn ^ b;
                writesCarry = 1'b1;
            end
            SBU_OP_CARRY_XOR_INV_BIT: begin
                carryOut = carryIn ^ ~b;
                writesCarry = 1'b1;
            end
            SBU_OP_BIT_TO_CARRY: begin
                carryOut = b;
                writesCarry = 1'b1;
            end
            SBU_OP_INV_BIT_TO_CARRY: begin
                carryOut = ~b;
                writesCarry = 1'b1;
            end
            SBU_OP_CARRY_TO_BIT: begin
                resultByte = carryIn ? (operand | sel) : (operand & ~sel);
                writesByte = 1'b1;
            end
            SBU_OP_INV_CARRY_TO_BIT: begin
                resultByte = carryIn ? (operand & ~sel) : (operand | sel);
                writesByte = 1'b1;
            end
            default: begin
                resultByte = operand;
            end
        endcase
    end
endmodule : sbu_bit_engine

// ---- tb/sbu_mem_model.sv ----
`timescale 1ns/1ps
// memory operand path: answers reads after waitCycles, never holds stale data
module sbu_mem_model (
    sys_clk,
    memRdReq,
    memByte,
    waitCycles,
    memRdData,
    memRdValid
);
    input wire logic sys_clk;
    input wire logic memRdReq;
    input wire logic [7:0] memByte;
    input wire logic [3:0] waitCycles;
    output logic [7:0] memRdData;
    output logic memRdValid;
    logic [3:0] cnt;
    initial begin
        memRdData = 8'h5A;
        memRdValid = 1'b0;
        cnt = 4'h0;
    end
    // data toggles when not valid so a late sample cannot pass by luck
    always @(posedge sys_clk) begin
        #1;
        if (memRdValid || memRdReq !== 1'b1) begin
            memRdValid = 1'b0;
            cnt = 4'h0;
            memRdData = ~memRdData;
        end else if (cnt == waitCycles) begin
            memRdValid = 1'b1;
            memRdData = memByte;
        end else begin
            cnt = cnt + 4'h1;
            memRdData = ~memRdData;
        end
    end
endmodule : sbu_mem_model

// ---- tb/tb_sbu_shift_bit_unit.sv ----
`timescale 1ns/1ps
module tb_sbu_shift_bit_unit;
    import sbu_pkg::*;
    logic sys_clk, resetn, clkEn, opValid, useMemory, bitFromReg, carryFlag, memRdValid;
    sbu_op_t opCode, op;
    logic [2:0] bitImm;
    logic [7:0] bitRegValue, regValue, memRdData, memByte;
    logic [3:0] waitCycles;
    logic opBusy, regWrEn, memRdReq, memWrReq, carryWrEn, carryWrData;
    logic zeroWrEn, zeroWrData, negWrEn, negWrData, opDone;
    logic [7:0] regWrData, memWrData;
    logic [31:0] r, r2;
    logic fr;
    logic [1:0] holdCycles;
    int nErrors, checked, cycles, k;
    integer seed;

    sbu_shift_bit_unit uut (.sys_clk(sys_clk), .resetn(resetn), .clkEn(clkEn),
        .opValid(opValid), .opCode(opCode), .useMemory(useMemory), .bitFromReg(bitFromReg),
        .bitImm(bitImm), .bitRegValue(bitRegValue), .regValue(regValue),
        .carryFlag(carryFlag), .memRdData(memRdData), .memRdValid(memRdValid),
        .opBusy(opBusy), .regWrEn(regWrEn), .regWrData(regWrData), .memRdReq(memRdReq),
        .memWrReq(memWrReq), .memWrData(memWrData), .carryWrEn(carryWrEn),
        .carryWrData(carryWrData), .zeroWrEn(zeroWrEn), .zeroWrData(zeroWrData),
        .negWrEn(negWrEn), .negWrData(negWrData), .opDone(opDone));

    sbu_mem_model mem (.sys_clk(sys_clk), .memRdReq(memRdReq), .memByte(memByte),
        .waitCycles(waitCycles), .memRdData(memRdData), .memRdValid(memRdValid));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic closeOut();
        if (nErrors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : closeOut

    // a hang counts against the run rather than stalling it
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            nErrors++;
            closeOut();
        end
    end

    // packs {regW, regD, memW, memD, cW, c, zW, z, nW, n, latency}
    function automatic logic [31:0] expectOf(sbu_op_t o, logic m, logic f, logic [2:0] imm,
        logic [7:0] br, logic [7:0] rv, logic c, logic [7:0] mb, logic [3:0] w);
        logic [7:0] src, res;
        logic [2:0] n;
        logic b, nc, sh, toMem, bw, cw, zw;
        sh = (o <= SBU_OP_ROTATE_RIGHT_VIA_CARRY);
        toMem = m && !sh;
        n = (f && o <= SBU_OP_BIT_TEST) ? br[2:0] : imm;
        src = toMem ? mb : rv;
        b = src[n];
        res = src;
        nc = c;
        case (o)
            SBU_OP_ARITH_SHIFT_LEFT, SBU_OP_LOGIC_SHIFT_LEFT: {nc, res} = {src, 1'b0};
            SBU_OP_ARITH_SHIFT_RIGHT: {res, nc} = {src[7], src};
            SBU_OP_LOGIC_SHIFT_RIGHT: {res, nc} = {1'b0, src};
            SBU_OP_ROTATE_LEFT: {nc, res} = {src[7], src[6:0], src[7]};
            SBU_OP_ROTATE_RIGHT: {res, nc} = {src[0], src[7:1], src[0]};
            SBU_OP_ROTATE_LEFT_VIA_CARRY: {nc, res} = {src, c};
            SBU_OP_ROTATE_RIGHT_VIA_CARRY: {res, nc} = {c, src};
            SBU_OP_BIT_SET: res[n] = 1'b1;
            SBU_OP_BIT_CLEAR: res[n] = 1'b0;
            SBU_OP_BIT_INVERT: res[n] = ~b;
            SBU_OP_CARRY_AND_BIT: nc = c & b;
            SBU_OP_CARRY_AND_INV_BIT: nc = c & ~b;
            SBU_OP_CARRY_OR_BIT: nc = c | b;
            SBU_OP_CARRY_OR_INV_BIT: nc = c | ~b;
            SBU_OP_CARRY_XOR_BIT: nc = c ^ b;
            SBU_OP_CARRY_XOR_INV_BIT: nc = c ^ ~b;
            SBU_OP_BIT_TO_CARRY: nc = b;
            SBU_OP_INV_BIT_TO_CARRY: nc = ~b;
            SBU_OP_CARRY_TO_BIT: res[n] = c;
            SBU_OP_INV_CARRY_TO_BIT: res[n] = ~c;
            default: nc = c;
        endcase
        bw = sh || o inside {SBU_OP_BIT_SET, SBU_OP_BIT_CLEAR, SBU_OP_BIT_INVERT,
            SBU_OP_CARRY_TO_BIT, SBU_OP_INV_CARRY_TO_BIT};
        cw = !(o inside {SBU_OP_BIT_SET, SBU_OP_BIT_CLEAR, SBU_OP_BIT_INVERT, SBU_OP_BIT_TEST,
            SBU_OP_CARRY_TO_BIT, SBU_OP_INV_CARRY_TO_BIT});
        zw = sh || o == SBU_OP_BIT_TEST;
        return {bw && !toMem, (bw && !toMem) ? res : 8'h00, bw && toMem,
            (bw && toMem) ? res : 8'h00, cw, cw & nc, zw, zw & (sh ? res == 8'h00 : ~b),
            sh, sh & res[7], toMem ? 8'h03 + 8'(w) : 8'h01};
    endfunction : expectOf

    // memory ops sit in read and write states; shifts never leave idle
    function automatic logic [6:0] expectBusy(sbu_op_t o, logic m, logic [3:0] w);
        return (m && o > SBU_OP_ROTATE_RIGHT_VIA_CARRY) ? 7'h02 + 7'(w) : 7'h00;
    endfunction : expectBusy

    task automatic compareCtl(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value at %0t: quiet/busy %h expected %h", $time, got, exp);
        end
    endtask : compareCtl

    task automatic compareVec(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value at %0t: op %0h got %h expected %h", $time, opCode, got, exp);
        end
    endtask : compareVec

    // operands held until done, opValid for one enabled cycle only; flag pulses gathered mid-cycle
    task automatic runOp(input sbu_op_t o, input logic m, input logic f, input logic [2:0] imm,
        input logic [7:0] br, input logic [7:0] rv, input logic c, input logic [7:0] mb,
        input logic [3:0] w);
        logic [31:0] got;
        logic quiet;
        int i;
        int busy;
        @(posedge sys_clk);
        #1;
        opCode = o;
        useMemory = m;
        bitFromReg = f;
        bitImm = imm;
        bitRegValue = br;
        regValue = rv;
        carryFlag = c;
        memByte = mb;
        waitCycles = w;
        opValid = 1'b1;
        got = 32'h0;
        quiet = 1'b1;
        busy = 0;
        // frozen first: an op taken early would show before clkEn returns
        clkEn = (holdCycles == 2'h0);
        for (i = 0; i < holdCycles; i++) begin
            @(negedge sys_clk);
            if ({regWrEn, memWrReq, carryWrEn, zeroWrEn, negWrEn, opDone, opBusy} !== 7'h00)
                quiet = 1'b0;
            @(posedge sys_clk);
        end
        #1;
        clkEn = 1'b1;
        @(posedge sys_clk);
        #1;
        opValid = 1'b0;
        for (i = 1; i < 40; i++) begin
            @(negedge sys_clk);
            if (regWrEn === 1'b1) got[31:23] = {1'b1, regWrData};
            if (memWrReq === 1'b1) got[22:14] = {1'b1, memWrData};
            if (carryWrEn === 1'b1) got[13:12] = {1'b1, carryWrData};
            if (zeroWrEn === 1'b1) got[11:10] = {1'b1, zeroWrData};
            if (negWrEn === 1'b1) got[9:8] = {1'b1, negWrData};
            if (opBusy === 1'b1) busy++;
            if (opDone === 1'b1) begin
                got[7:0] = 8'(i);
                break;
            end
        end
        compareVec(got, expectOf(o, m, f, imm, br, rv, c, mb, w));
        compareCtl({quiet, 7'(busy)}, {1'b1, expectBusy(o, m, w)});
    endtask : runOp

    initial begin
        seed = 32'h500f74bf;
        nErrors = 0;
        checked = 0;
        cycles = 0;
        resetn = 1'b0;
        clkEn = 1'b1;
        opValid = 1'b0;
        opCode = SBU_OP_NOP;
        useMemory = 1'b0;
        bitFromReg = 1'b0;
        bitImm = 3'h0;
        bitRegValue = 8'h00;
        regValue = 8'h00;
        carryFlag = 1'b0;
        memByte = 8'h00;
        waitCycles = 4'h0;
        holdCycles = 2'h0;
        repeat (12) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        runOp(SBU_OP_ROTATE_LEFT_VIA_CARRY, 0, 0, 3'h0, 8'h00, 8'h80, 1, 8'h00, 4'h0);
        runOp(SBU_OP_ARITH_SHIFT_RIGHT, 1, 0, 3'h0, 8'h00, 8'h81, 0, 8'hFF, 4'h0);
        runOp(SBU_OP_LOGIC_SHIFT_LEFT, 0, 0, 3'h0, 8'h00, 8'h80, 0, 8'h00, 4'h0);
        runOp(SBU_OP_ROTATE_RIGHT, 0, 0, 3'h0, 8'h00, 8'h01, 0, 8'h00, 4'h0);
        runOp(SBU_OP_CARRY_XOR_INV_BIT, 0, 1, 3'h2, 8'h05, 8'h04, 1, 8'h00, 4'h0);
        runOp(SBU_OP_BIT_CLEAR, 0, 1, 3'h7, 8'hF8, 8'hFF, 0, 8'h00, 4'h0);
        runOp(SBU_OP_BIT_INVERT, 1, 0, 3'h7, 8'h00, 8'h00, 0, 8'h80, 4'h5);
        runOp(SBU_OP_BIT_TEST, 1, 0, 3'h0, 8'h00, 8'h01, 0, 8'hFE, 4'h2);
        // random mix; carry ops without inversion keep the immediate bit number
        for (k = 0; k < 300; k++) begin
            r = $random(seed);
            r2 = $random(seed);
            op = sbu_op_t'(5'(32'd1 + r[15:0] % 16'd22));
            fr = r[16] && !(op inside {SBU_OP_CARRY_AND_BIT, SBU_OP_CARRY_OR_BIT,
                SBU_OP_CARRY_XOR_BIT, SBU_OP_BIT_TO_CARRY, SBU_OP_CARRY_TO_BIT});
            holdCycles = r2[25:24];
            runOp(op, r[17], fr, r[20:18], r2[7:0], r2[15:8], r[21], r2[23:16],
                r[25:22]);
        end
        closeOut();
    end
endmodule : tb_sbu_shift_bit_unit
